// File: pkg/sprs_regs.svh
// Purpose: offsets, field positions and reset values for the serial pin route block
// Assumes: byte addresses are four times the register index
// Notes: definitions only
`ifndef SPRS_REGS_SVH
`define SPRS_REGS_SVH
`define SPRS_IDX_ROUTE_A      10'h18A
`define SPRS_IDX_ROUTE_B      10'h18B
`define SPRS_IDX_LV_CTRL      10'h190
`define SPRS_ADDR_W           12
`define SPRS_ADDR_ROUTE_A     12'h628
`define SPRS_ADDR_ROUTE_B     12'h62C
`define SPRS_ADDR_LV_CTRL     12'h640
`define SPRS_RESET_BYTE       8'h00
`define SPRS_ROUTE_B_MASK     8'h37
`define SPRS_LV_PROTECT_BIT   0
`define SPRS_LV_ENABLE_MASK   8'hFE
`define SPRS_NUM_PINS         10
`endif

// File: pkg/sprs_pkg.sv
// Purpose: types for the serial pin route block
// Assumes: header sprs_regs.svh holds numbers
// Notes: pin index order fixed below
package sprs_pkg;
  // general port pins that the channel may take over
  typedef enum logic [3:0] {
    SPRS_PIN_P37 = 4'h0,
    SPRS_PIN_P34 = 4'h1,
    SPRS_PIN_P00 = 4'h2,
    SPRS_PIN_P20 = 4'h3,
    SPRS_PIN_P22 = 4'h4,
    SPRS_PIN_P45 = 4'h5,
    SPRS_PIN_P35 = 4'h6,
    SPRS_PIN_P05 = 4'h7,
    SPRS_PIN_P21 = 4'h8,
    SPRS_PIN_P33 = 4'h9,
    SPRS_PIN_P31 = 4'hA,
    SPRS_PIN_NONE = 4'hF
  } sprs_pin_e;
  typedef struct packed {
    logic       read;
    logic       write;
    logic [11:0] address;
    logic [31:0] writedata;
  } sprs_bus_req_s;
  typedef struct packed {
    logic out;
    logic oe;
  } sprs_drive_s;
endpackage

// File: core/sprs_decode.sv
// Purpose: turn a route code into a pin index
// Assumes: forbidden codes are mapped to no pin
// Notes: kind selects which signal's table applies
`timescale 1ns/1ps
module sprs_decode (
  input  wire logic [1:0]        kind_i,
  input  wire logic [2:0]        code_i,
  output sprs_pkg::sprs_pin_e    pin_o
);
  always_comb begin
    pin_o = sprs_pkg::SPRS_PIN_NONE;
    case (kind_i)
      2'h0: begin
        case (code_i)
          3'h1: pin_o = sprs_pkg::SPRS_PIN_P37;
          3'h2: pin_o = sprs_pkg::SPRS_PIN_P34;
          3'h3: pin_o = sprs_pkg::SPRS_PIN_P00;
          3'h4: pin_o = sprs_pkg::SPRS_PIN_P20;
          3'h7: pin_o = sprs_pkg::SPRS_PIN_P22;
          default: pin_o = sprs_pkg::SPRS_PIN_NONE;
        endcase
      end
      2'h1: begin
        case (code_i)
          3'h1: pin_o = sprs_pkg::SPRS_PIN_P34;
          3'h2: pin_o = sprs_pkg::SPRS_PIN_P37;
          3'h3: pin_o = sprs_pkg::SPRS_PIN_P45;
          3'h4: pin_o = sprs_pkg::SPRS_PIN_P20;
          3'h7: pin_o = sprs_pkg::SPRS_PIN_P22;
          default: pin_o = sprs_pkg::SPRS_PIN_NONE;
        endcase
      end
      2'h2: begin
        case (code_i)
          3'h1: pin_o = sprs_pkg::SPRS_PIN_P35;
          3'h2: pin_o = sprs_pkg::SPRS_PIN_P05;
          3'h4: pin_o = sprs_pkg::SPRS_PIN_P21;
          default: pin_o = sprs_pkg::SPRS_PIN_NONE;
        endcase
      end
      default: begin
        case (code_i[1:0])
          2'h1: pin_o = sprs_pkg::SPRS_PIN_P33;
          2'h2: pin_o = sprs_pkg::SPRS_PIN_P31;
          default: pin_o = sprs_pkg::SPRS_PIN_NONE;
        endcase
      end
    endcase
  end
endmodule

// File: core/sprs_pin_cell.sv
// Purpose: one port pin's output path with serial takeover
// Assumes: open drain drives only low
// Notes: unselected pins pass the port's own drive
`timescale 1ns/1ps
module sprs_pin_cell (
  input  wire logic               sel_i,
  input  wire logic               ser_out_i,
  input  wire logic               ser_oe_i,
  input  wire logic               open_drain_i,
  input  sprs_pkg::sprs_drive_s   port_i,
  output sprs_pkg::sprs_drive_s   pin_o
);
  always_comb begin
    pin_o = port_i;
    if (sel_i) begin
      pin_o.out = open_drain_i ? 1'b0 : ser_out_i;
      pin_o.oe  = open_drain_i ? (ser_oe_i & ~ser_out_i) : ser_oe_i;
    end
  end
endmodule

// File: core/sprs_top.sv
// Purpose: pin routing and low-voltage mode control for serial channel 2
// Assumes: Avalon-MM slave, one cycle waitrequest on every access
// Notes: pin drives are registered, so they lag settings by one cycle
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "sprs_regs.svh"
module sprs_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [11:0]              avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic [31:0]                   avs_readdata_o,
  output logic                          avs_waitrequest_o,
  output logic [1:0]                    avs_response_o,
  input  wire logic                     tx_serial_data_signal_i,
  input  wire logic                     tx_serial_data_oe_i,
  input  wire logic                     transfer_clock_signal_i,
  input  wire logic                     transfer_clock_oe_i,
  input  wire logic                     flow_control_signal_i,
  input  wire logic                     flow_control_oe_i,
  output logic                          rx_serial_clock_signal_o,
  output logic                          transfer_clock_in_o,
  output logic                          flow_control_in_o,
  input  wire logic [9:0]               port_pin_in_i,
  input  wire logic [9:0]               port_out_i,
  input  wire logic [9:0]               port_oe_i,
  output logic [9:0]                    pin_out_o,
  output logic [9:0]                    pin_oe_o,
  output logic [2:0]                    serial_lowvolt_enable_o,
  output logic [3:0]                    irq_input_lowvolt_enable_o
);
  logic [7:0] serial_pin_route_a;
  logic [7:0] serial_pin_route_b;
  logic [7:0] low_voltage_signal_ctrl;
  logic       ack;
  logic       hit_a;
  logic       hit_b;
  logic       hit_lv;
  logic       wr_go;
  logic [7:0] next_rdata;
  sprs_pkg::sprs_pin_e tx_pin;
  sprs_pkg::sprs_pin_e rx_pin;
  sprs_pkg::sprs_pin_e ck_pin;
  sprs_pkg::sprs_pin_e fc_pin;
  sprs_pkg::sprs_drive_s cell_port [`SPRS_NUM_PINS];
  sprs_pkg::sprs_drive_s cell_pin  [`SPRS_NUM_PINS];
  logic [9:0] next_pin_out;
  logic [9:0] next_pin_oe;

  assign hit_a  = (avs_address_i == `SPRS_ADDR_ROUTE_A);
  assign hit_b  = (avs_address_i == `SPRS_ADDR_ROUTE_B);
  assign hit_lv = (avs_address_i == `SPRS_ADDR_LV_CTRL);
  // the write lands on the edge where waitrequest is sampled low
  assign wr_go  = avs_write_i & ack & avs_byteenable_i[0];

  // one wait cycle, then the answer; ack drops after it so back to back works
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack);
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (hit_a) begin
      next_rdata = serial_pin_route_a;
    end else if (hit_b) begin
      next_rdata = serial_pin_route_b & `SPRS_ROUTE_B_MASK;
    end else if (hit_lv) begin
      next_rdata = low_voltage_signal_ctrl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else begin
      avs_readdata_o <= {24'h00_0000, next_rdata};
      avs_response_o <= (hit_a | hit_b | hit_lv) ? 2'h0 : 2'h3;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_pin_route_a <= `SPRS_RESET_BYTE;
    end else if (wr_go && hit_a) begin
      serial_pin_route_a <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_pin_route_b <= `SPRS_RESET_BYTE;
    end else if (wr_go && hit_b) begin
      serial_pin_route_b <= avs_writedata_i[7:0] & `SPRS_ROUTE_B_MASK;
    end
  end

  // protect bit always writable; enables only while protect already reads 1
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_voltage_signal_ctrl <= `SPRS_RESET_BYTE;
    end else if (wr_go && hit_lv) begin
      low_voltage_signal_ctrl[`SPRS_LV_PROTECT_BIT] <= avs_writedata_i[`SPRS_LV_PROTECT_BIT];
      if (low_voltage_signal_ctrl[`SPRS_LV_PROTECT_BIT]) begin
        low_voltage_signal_ctrl[7:1] <= avs_writedata_i[7:1];
      end
    end
  end

  sprs_decode u_dec_tx (
    .kind_i (2'h0),
    .code_i (serial_pin_route_a[2:0]),
    .pin_o  (tx_pin)
  );
  sprs_decode u_dec_rx (
    .kind_i (2'h1),
    .code_i (serial_pin_route_a[6:4]),
    .pin_o  (rx_pin)
  );
  sprs_decode u_dec_ck (
    .kind_i (2'h2),
    .code_i (serial_pin_route_b[2:0]),
    .pin_o  (ck_pin)
  );
  sprs_decode u_dec_fc (
    .kind_i (2'h3),
    .code_i ({1'b0, serial_pin_route_b[5:4]}),
    .pin_o  (fc_pin)
  );

  // transmit and receive may share a pin code; transmit owns the output path
  genvar g;
  generate
    for (g = 0; g < `SPRS_NUM_PINS; g++) begin : g_pin
      logic sel_tx;
      logic sel_ck;
      logic sel_fc;
      assign sel_tx = (tx_pin == sprs_pkg::sprs_pin_e'(g));
      assign sel_ck = (ck_pin == sprs_pkg::sprs_pin_e'(g));
      assign sel_fc = (fc_pin == sprs_pkg::sprs_pin_e'(g));
      assign cell_port[g] = '{out: port_out_i[g], oe: port_oe_i[g]};
      sprs_pin_cell u_cell (
        .sel_i        (sel_tx | sel_ck | sel_fc),
        .ser_out_i    (sel_tx ? tx_serial_data_signal_i :
                       sel_ck ? transfer_clock_signal_i : flow_control_signal_i),
        .ser_oe_i     (sel_tx ? tx_serial_data_oe_i :
                       sel_ck ? transfer_clock_oe_i : flow_control_oe_i),
        .open_drain_i (sel_tx & low_voltage_signal_ctrl[3]),
        .port_i       (cell_port[g]),
        .pin_o        (cell_pin[g])
      );
      assign next_pin_out[g] = cell_pin[g].out;
      assign next_pin_oe[g]  = cell_pin[g].oe;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= 10'h000;
      pin_oe_o  <= 10'h000;
    end else begin
      pin_out_o <= next_pin_out;
      pin_oe_o  <= next_pin_oe;
    end
  end

  // unrouted inputs idle high so a missing flow-control pin reads deasserted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_serial_clock_signal_o <= 1'b1;
      transfer_clock_in_o      <= 1'b1;
      flow_control_in_o        <= 1'b1;
    end else begin
      rx_serial_clock_signal_o <= (rx_pin == sprs_pkg::SPRS_PIN_NONE) ? 1'b1 : port_pin_in_i[rx_pin];
      transfer_clock_in_o      <= (ck_pin == sprs_pkg::SPRS_PIN_NONE) ? 1'b1 : port_pin_in_i[ck_pin];
      // the second flow pin has no slot on the ten-pin bus, so it reads as unrouted
      flow_control_in_o        <= (fc_pin > sprs_pkg::SPRS_PIN_P33) ? 1'b1 : port_pin_in_i[fc_pin];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_lowvolt_enable_o    <= 3'h0;
      irq_input_lowvolt_enable_o <= 4'h0;
    end else begin
      serial_lowvolt_enable_o    <= low_voltage_signal_ctrl[3:1];
      irq_input_lowvolt_enable_o <= low_voltage_signal_ctrl[7:4];
    end
  end
endmodule

// File: verification/sprs_top_monitor.sv
// Purpose: port checker for sprs_top
// Assumes: bench keeps routed pins apart, byte lane 0 always on
// Notes: pin checks wait for quiet inputs since drives lag
`timescale 1ns/1ps
`include "sprs_regs.svh"
module sprs_top_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic tx_serial_data_signal_i,
  input wire logic tx_serial_data_oe_i,
  input wire logic transfer_clock_signal_i,
  input wire logic transfer_clock_oe_i,
  input wire logic flow_control_signal_i,
  input wire logic flow_control_oe_i,
  input wire logic rx_serial_clock_signal_o,
  input wire logic transfer_clock_in_o,
  input wire logic [9:0] port_pin_in_i,
  input wire logic [9:0] port_out_i,
  input wire logic [9:0] port_oe_i,
  input wire logic [9:0] pin_out_o,
  input wire logic [9:0] pin_oe_o,
  input wire logic [2:0] serial_lowvolt_enable_o,
  input wire logic [3:0] irq_input_lowvolt_enable_o
);
  localparam logic [3:0] TXP [8] = '{4'hF, 4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'hF, 4'h4};
  localparam logic [3:0] RXP [8] = '{4'hF, 4'h1, 4'h0, 4'h5, 4'h3, 4'hF, 4'hF, 4'h4};
  localparam logic [3:0] CKP [8] = '{4'hF, 4'h6, 4'h7, 4'hF, 4'h8, 4'hF, 4'hF, 4'hF};
  localparam logic [3:0] FLP [4] = '{4'hF, 4'h9, 4'hF, 4'hF};
  logic [7:0] ra, rb, lw;
  logic prot;
  logic [1:0] qt;
  logic [35:0] prv;
  logic [9:0] eo, ee, rm;
  logic [3:0] tp, rp, cp, fp;
  wire [6:0] lv = {irq_input_lowvolt_enable_o, serial_lowvolt_enable_o};
  wire ack = !avs_waitrequest_o;
  wire wr = ack && avs_write_i;
  wire [35:0] sv = {tx_serial_data_signal_i, tx_serial_data_oe_i, transfer_clock_signal_i, transfer_clock_oe_i,
    flow_control_signal_i, flow_control_oe_i, port_pin_in_i, port_out_i, port_oe_i};
  wire qk = qt[1] && sv == prv;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of software writes; any access restarts the quiet count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ra <= 8'h00;
      rb <= 8'h00;
      lw <= 8'h00;
      prot <= 1'b0;
      qt <= 2'h0;
      prv <= '0;
    end else begin
      prv <= sv;
      qt <= (ack || sv != prv) ? 2'h0 : qt + {1'b0, qt != 2'h3};
      if (wr && avs_address_i == `SPRS_ADDR_ROUTE_A) ra <= avs_writedata_i[7:0];
      if (wr && avs_address_i == `SPRS_ADDR_ROUTE_B) rb <= avs_writedata_i[7:0];
      if (wr && avs_address_i == `SPRS_ADDR_LV_CTRL) begin
        lw <= avs_writedata_i[7:0];
        prot <= avs_writedata_i[0];
      end
    end
  end
  always_comb begin
    tp = TXP[ra[2:0]];
    rp = RXP[ra[6:4]];
    cp = CKP[rb[2:0]];
    fp = FLP[rb[5:4]];
    eo = port_out_i;
    ee = port_oe_i;
    rm = 10'h3FF;
    if (fp != 4'hF) begin
      eo[fp] = flow_control_signal_i;
      ee[fp] = flow_control_oe_i;
    end
    if (cp != 4'hF) begin
      eo[cp] = transfer_clock_signal_i;
      ee[cp] = transfer_clock_oe_i;
    end
    if (tp != 4'hF) begin
      eo[tp] = tx_serial_data_signal_i & ~serial_lowvolt_enable_o[2];
      ee[tp] = tx_serial_data_oe_i & ~(serial_lowvolt_enable_o[2] & tx_serial_data_signal_i);
    end
    // the receive pin's own drive is left open, so it is not judged
    if (rp != 4'hF) rm[rp] = 1'b0;
  end
  property p_pin_oe;
    qk |-> (pin_oe_o & rm) == (ee & rm);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong for routing");
  property p_pin_out;
    qk |-> ((pin_out_o ^ eo) & ee & rm) == 10'h000;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin level wrong for routing");
  property p_rx_in;
    qk |-> rx_serial_clock_signal_o == (rp == 4'hF ? 1'b1 : port_pin_in_i[rp]);
  endproperty
  a_rx_in: assert property (p_rx_in) else $error("receive input not from routed pin");
  property p_clk_in;
    qk |-> transfer_clock_in_o == (cp == 4'hF ? 1'b1 : port_pin_in_i[cp]);
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("clock input not from routed pin");
  property p_rsv_zero;
    ack && !avs_write_i && avs_address_i == `SPRS_ADDR_ROUTE_B |-> avs_readdata_o[7:0] == (rb & 8'h37);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("second route register readback wrong");
  property p_lv_lock;
    wr && avs_address_i == `SPRS_ADDR_LV_CTRL && !prot |=> $stable(lv) ##1 $stable(lv);
  endproperty
  a_lv_lock: assert property (p_lv_lock) else $error("enables changed while protected");
  property p_lv_open;
    wr && avs_address_i == `SPRS_ADDR_LV_CTRL && prot |-> ##[1:2] lv == lw[7:1];
  endproperty
  a_lv_open: assert property (p_lv_open) else $error("enables not written while open");
  property p_reset;
    $rose(rst_n_i) |-> lv == 7'h00 && avs_waitrequest_o;
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
endmodule
bind sprs_top sprs_top_monitor u_mon (.*);

// File: verification/sprs_pin_model.sv
// Purpose: port pins beyond the route block
// Assumes: each pin has an external driver and a pull-up
// Notes: block drive wins, so the bench never fights it
`timescale 1ns/1ps
module sprs_pin_model (
  input  wire logic [9:0] drv_out_i,
  input  wire logic [9:0] drv_oe_i,
  input  wire logic [9:0] ext_oe_i,
  input  wire logic [9:0] ext_val_i,
  output logic [9:0]      level_o
);
  assign level_o = (drv_oe_i & drv_out_i) | (~drv_oe_i & ((ext_oe_i & ext_val_i) | ~ext_oe_i));
endmodule

// File: verification/sprs_top_tb_top.sv
// Purpose: register and routing tests for sprs_top
// Assumes: one wait cycle per access, outputs lag one cycle
// Notes: routed pins chosen so no two signals share a pin
`timescale 1ns/1ps
`include "sprs_regs.svh"
module sprs_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [11:0] avs_address_i = 12'h000;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [1:0] avs_response_o, rs;
  logic tx_serial_data_signal_i = 1'b1, tx_serial_data_oe_i = 1'b1, flow_control_signal_i = 1'b0;
  logic transfer_clock_signal_i = 1'b1, transfer_clock_oe_i = 1'b1, flow_control_oe_i = 1'b1;
  logic rx_serial_clock_signal_o, transfer_clock_in_o, flow_control_in_o;
  logic [9:0] port_pin_in_i, pin_out_o, pin_oe_o, port_oe_i = 10'h0C0;
  logic [2:0] serial_lowvolt_enable_o;
  logic [3:0] irq_input_lowvolt_enable_o;
  int mismatches = 0, checks_done = 0;
  localparam logic [9:0] TOE [8] = '{10'h0C0, 10'h0C1, 10'h0C2, 10'h0C4, 10'h0C8, 10'h0C0, 10'h0C0, 10'h0D0};
  localparam logic RXL [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] RB [4] = '{8'hC9, 8'h12, 8'h24, 8'hC8};
  localparam logic [9:0] BOE [4] = '{10'h0D0, 10'h2D0, 10'h1D0, 10'h0D0};
  localparam logic FLI [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  localparam logic [11:0] RA = `SPRS_ADDR_ROUTE_A;
  localparam logic [11:0] LV = `SPRS_ADDR_LV_CTRL;
  sprs_top dut (.*, .avs_byteenable_i(4'hF), .port_out_i(10'h155));
  sprs_pin_model pins (.drv_out_i(pin_out_o), .drv_oe_i(pin_oe_o), .ext_oe_i(10'h3FF), .ext_val_i(10'h2A5),
    .level_o(port_pin_in_i));
  always #25 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    @(posedge clk_i iff !avs_waitrequest_o);
    q = avs_readdata_o;
    rs = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk(RA, 8'h00);
    rchk(`SPRS_ADDR_ROUTE_B, 8'h00);
    rchk(LV, 8'h00);
    bus(1'b0, 12'h630, 8'h00);
    chk({30'h0, rs}, 32'h3);
    // routes set first and held while the channel drives its pins
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, RA, {1'b0, 3'(i + 2), 1'b0, 3'(i)});
      rchk(RA, {1'b0, 3'(i + 2), 1'b0, 3'(i)});
      settle();
      chk({22'h0, pin_oe_o}, {22'h0, TOE[i]});
      chk({31'h0, rx_serial_clock_signal_o}, {31'h0, RXL[i]});
    end
    foreach (RB[i]) begin
      bus(1'b1, `SPRS_ADDR_ROUTE_B, RB[i]);
      rchk(`SPRS_ADDR_ROUTE_B, RB[i] & 8'h37);
      settle();
      chk({22'h0, pin_oe_o}, {22'h0, BOE[i]});
      chk({31'h0, flow_control_in_o}, {31'h0, FLI[i]});
      chk({31'h0, transfer_clock_in_o}, 32'h1);
    end
    bus(1'b1, LV, 8'hFE);
    rchk(LV, 8'h00);
    bus(1'b1, LV, 8'h00);
    bus(1'b1, LV, 8'h01);
    bus(1'b1, LV, 8'hFF);
    rchk(LV, 8'hFF);
    settle();
    chk({25'h0, irq_input_lowvolt_enable_o, serial_lowvolt_enable_o}, 32'h7F);
    chk({31'h0, pin_oe_o[4]}, 32'h0);
    @(posedge clk_i);
    tx_serial_data_signal_i <= 1'b0;
    settle();
    chk({30'h0, pin_oe_o[4], pin_out_o[4]}, 32'h2);
    bus(1'b1, LV, 8'h00);
    bus(1'b1, LV, 8'hF0);
    rchk(LV, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk(RA, 8'h00);
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
endmodule
